// File: core/mpt_pkg.sv
// constants, register map and field layout of the match-based pwm timer
//
// Summary of operation
// - 32-bit up counter advances once per wrap of a programmable 32-bit prescaler.
// - timer mode counts pclk; counter mode counts edges of a selected capture input.
// - seven match registers feed six single-edge or three double-edge outputs, or a mix.
// - each match may continue, stop or reset the count, each with optional interrupt.
// - match 0 sets the cycle period by resetting the count, shared by all outputs.
// - single-edge outputs rise on the period match unless held constantly low.
// - one further match register sets where a single-edge output falls.
// - double-edge outputs rise on one match and fall on the next; either order.
// - double-edge edges may sit at any count position within the cycle.
// - period and width accept any count value.
// - new match values act only after software releases them; in modulation mode, at cycle start.
// - without modulation mode the block is a plain timer with match and capture.
// - two units synchronise: master enable drives slave start simultaneously.
// - four 32-bit capture channels store the count on input edges, optional interrupt.
// - four match outputs go low, high, toggle or stay on their match.
package mpt_pkg;
  localparam int NMATCH = 7;
  localparam int NCAP = 4;
  localparam int NEXT = 4;
  localparam int NPWM = 6;
  localparam int AW = 12;
  // register byte offsets
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_CLEAR = 12'h004;
  localparam logic [11:0] OFS_ENABLE = 12'h008;
  localparam logic [11:0] OFS_CTRL = 12'h00c;
  localparam logic [11:0] OFS_COUNT = 12'h010;
  localparam logic [11:0] OFS_PSC_TERM = 12'h014;
  localparam logic [11:0] OFS_PSC_COUNT = 12'h018;
  localparam logic [11:0] OFS_MATCH_CTRL = 12'h01c;
  localparam logic [11:0] OFS_RELEASE = 12'h020;
  localparam logic [11:0] OFS_PWM_CTRL = 12'h024;
  localparam logic [11:0] OFS_CAP_CTRL = 12'h028;
  localparam logic [11:0] OFS_EXT_CTRL = 12'h02c;
  localparam logic [11:0] OFS_MATCH_BASE = 12'h040;
  localparam logic [11:0] OFS_CAP_BASE = 12'h060;
  // control register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_RESET = 1;
  localparam int CTRL_PWM = 2;
  localparam int CTRL_CNTMODE = 3;
  localparam int CTRL_EDGE_LO = 4;
  localparam int CTRL_SRC_LO = 6;
  localparam int CTRL_SLAVE = 8;
  localparam int CTRL_W = 9;
  // per-match control: three bits per match register
  localparam int MCR_INT = 0;
  localparam int MCR_RST = 1;
  localparam int MCR_STOP = 2;
  localparam int MCR_W = 3;
  // per-capture control: three bits per channel
  localparam int CCR_RISE = 0;
  localparam int CCR_FALL = 1;
  localparam int CCR_INT = 2;
  localparam int CCR_W = 3;
  // pwm control: double-edge select and output enable, bit k-1 for output k
  localparam int PCR_DBL_LO = 0;
  localparam int PCR_ENA_LO = 8;
  // external match control: output state in low bits, two action bits per output above
  localparam int EXT_ACT_LO = 4;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_LOW = 2'h1;
  localparam logic [1:0] EXT_HIGH = 2'h2;
  localparam logic [1:0] EXT_TOGGLE = 2'h3;
  // status layout: matches in low bits, captures above
  localparam int ST_W = NMATCH + NCAP;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : mpt_pkg

// File: core/mpt_presc_if.sv
// prescaler hand-off between the timer core and its prescaler
interface mpt_presc_if #(parameter int W = 32);
  logic [W-1:0] terminal;
  logic step;
  logic clear;
  logic [W-1:0] count;
  logic tick;
  modport ctl (output terminal, output step, output clear, input count, input tick);
  modport core (input terminal, input step, input clear, output count, output tick);
endinterface : mpt_presc_if

// File: core/mpt_prescaler.sv
// prescaler: counts steps up to a terminal value and pulses a tick on wrap
module mpt_prescaler (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  mpt_presc_if.core p // terminal, step and clear in; count and tick out
);
  logic [$bits(p.count)-1:0] cnt;

  assign p.count = cnt;
  assign p.tick = p.step & ~p.clear & (cnt == p.terminal);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (p.clear) begin
      cnt <= '0;
    end else if (p.step) begin
      if (cnt == p.terminal) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule : mpt_prescaler

// File: core/mpt_capture.sv
// one capture channel: edge detect on its input and a snapshot of the count
module mpt_capture #(
  parameter int W = 32
) (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic sample, // capture input level
  input wire logic rise_en, // capture on rising edge
  input wire logic fall_en, // capture on falling edge
  input wire logic [W-1:0] count, // live counter value
  output logic rise, // rising edge seen, one cycle
  output logic fall, // falling edge seen, one cycle
  output logic hit, // capture taken, one cycle
  output logic [W-1:0] value // stored count
);
  logic prev;

  assign rise = sample & ~prev;
  assign fall = ~sample & prev;
  assign hit = (rise & rise_en) | (fall & fall_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else begin
      prev <= sample;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= '0;
    end else if (hit) begin
      value <= count;
    end
  end
endmodule : mpt_capture

// File: core/mpt_timer.sv
// pwm timer top: apb registers, counter, matches, pwm and match outputs, capture
//
// The placing of the registers and register access over APB were left to the implementer.
module mpt_timer #(
  parameter int W = 32
) (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [mpt_pkg::AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [mpt_pkg::NCAP-1:0] cap_in, // capture inputs
  input wire logic sync_en_in, // enable from master unit
  output logic sync_en_out, // enable towards slave unit
  output logic [mpt_pkg::NPWM-1:0] pwm_out, // modulated outputs 1..6
  output logic [mpt_pkg::NEXT-1:0] match_out, // external match outputs
  output logic irq // interrupt, level
);
  localparam int NM = mpt_pkg::NMATCH;
  localparam int NC = mpt_pkg::NCAP;
  // registers of one array sit one word apart
  localparam logic [mpt_pkg::AW-1:0] STRIDE = 12'h004;

  logic [mpt_pkg::CTRL_W-1:0] ctrl;
  logic [W-1:0] psc_term;
  logic [W-1:0] tc;
  logic [NM*mpt_pkg::MCR_W-1:0] match_ctrl;
  logic [NM-1:0] release_req;
  logic [15:0] pwm_ctrl;
  logic [NC*mpt_pkg::CCR_W-1:0] cap_ctrl;
  logic [2*mpt_pkg::NEXT-1:0] ext_act;
  logic [mpt_pkg::ST_W-1:0] status;
  logic [mpt_pkg::ST_W-1:0] int_en;
  logic [W-1:0] shadow [NM];
  logic [W-1:0] active [NM];
  logic [W-1:0] cap_val [NC];
  logic [NC-1:0] cap_rise;
  logic [NC-1:0] cap_fall;
  logic [NC-1:0] cap_hit;
  logic [NM-1:0] hit;
  logic [NM-1:0] rst_mask;
  logic [NM-1:0] stop_mask;
  logic [NM-1:0] int_mask;
  logic [NM-1:0] applied;
  logic running;
  logic step;
  logic src_rise;
  logic src_fall;
  logic pwm_mode;
  logic cycle_start;
  logic rst_any;
  logic stop_any;
  logic setup;
  logic access;
  logic wr;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_release;
  logic wr_ext;
  logic addr_ok;
  logic [31:0] next_rdata;
  logic [mpt_pkg::ST_W-1:0] events;

  mpt_presc_if #(.W(W)) presc ();

  mpt_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .p(presc.core)
  );

  for (genvar c = 0; c < NC; c++) begin : g_cap
    mpt_capture #(.W(W)) u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .sample(cap_in[c]),
      .rise_en(cap_ctrl[c*mpt_pkg::CCR_W+mpt_pkg::CCR_RISE]),
      .fall_en(cap_ctrl[c*mpt_pkg::CCR_W+mpt_pkg::CCR_FALL]),
      .count(tc),
      .rise(cap_rise[c]),
      .fall(cap_fall[c]),
      .hit(cap_hit[c]),
      .value(cap_val[c])
    );
  end

  for (genvar m = 0; m < NM; m++) begin : g_mcr
    assign int_mask[m] = match_ctrl[m*mpt_pkg::MCR_W+mpt_pkg::MCR_INT];
    assign rst_mask[m] = match_ctrl[m*mpt_pkg::MCR_W+mpt_pkg::MCR_RST];
    assign stop_mask[m] = match_ctrl[m*mpt_pkg::MCR_W+mpt_pkg::MCR_STOP];
    assign hit[m] = presc.tick & (tc == active[m]);
  end

  // ---- apb slave, zero wait states
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign wr = access & pwrite & addr_ok;
  // write strobes of the registers whose writes have side effects
  assign wr_ctrl = wr & (paddr == mpt_pkg::OFS_CTRL);
  assign wr_clear = wr & (paddr == mpt_pkg::OFS_CLEAR);
  assign wr_release = wr & (paddr == mpt_pkg::OFS_RELEASE);
  assign wr_ext = wr & (paddr == mpt_pkg::OFS_EXT_CTRL);

  // ---- count clock selection and run control
  assign pwm_mode = ctrl[mpt_pkg::CTRL_PWM];
  // a slave follows the master enable so both units start on one edge
  assign running = ctrl[mpt_pkg::CTRL_EN] | (ctrl[mpt_pkg::CTRL_SLAVE] & sync_en_in);
  assign sync_en_out = ctrl[mpt_pkg::CTRL_EN];
  assign src_rise = cap_rise[ctrl[mpt_pkg::CTRL_SRC_LO +: 2]];
  assign src_fall = cap_fall[ctrl[mpt_pkg::CTRL_SRC_LO +: 2]];
  always_comb begin
    if (ctrl[mpt_pkg::CTRL_CNTMODE]) begin
      step = (ctrl[mpt_pkg::CTRL_EDGE_LO] & src_rise)
        | (ctrl[mpt_pkg::CTRL_EDGE_LO+1] & src_fall);
    end else begin
      step = 1'b1;
    end
  end

  assign presc.terminal = psc_term;
  assign presc.step = running & step;
  assign presc.clear = ctrl[mpt_pkg::CTRL_RESET];

  // period match always restarts the cycle in modulation mode
  assign cycle_start = pwm_mode & hit[0];
  assign rst_any = |(hit & rst_mask) | cycle_start;
  assign stop_any = |(hit & stop_mask);

  // ---- main counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tc <= '0;
    end else if (ctrl[mpt_pkg::CTRL_RESET]) begin
      tc <= '0;
    end else if (presc.tick) begin
      if (rst_any) begin
        tc <= '0;
      end else begin
        tc <= tc + 1'b1;
      end
    end
  end

  // ---- control register; a software write wins over a stop on match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[mpt_pkg::CTRL_W-1:0];
    end else if (stop_any) begin
      ctrl[mpt_pkg::CTRL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_term <= '0;
      match_ctrl <= '0;
      pwm_ctrl <= '0;
      cap_ctrl <= '0;
      ext_act <= '0;
      int_en <= '0;
    end else if (wr) begin
      case (paddr)
        mpt_pkg::OFS_PSC_TERM: psc_term <= pwdata[W-1:0];
        mpt_pkg::OFS_MATCH_CTRL: match_ctrl <= pwdata[NM*mpt_pkg::MCR_W-1:0];
        mpt_pkg::OFS_PWM_CTRL: pwm_ctrl <= pwdata[15:0];
        mpt_pkg::OFS_CAP_CTRL: cap_ctrl <= pwdata[NC*mpt_pkg::CCR_W-1:0];
        mpt_pkg::OFS_EXT_CTRL: begin
          ext_act <= pwdata[mpt_pkg::EXT_ACT_LO +: 2*mpt_pkg::NEXT];
        end
        mpt_pkg::OFS_ENABLE: int_en <= pwdata[mpt_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ---- match shadows, release and transfer to the active set
  always_comb begin
    for (int i = 0; i < NM; i++) begin
      // plain timer applies at once; modulation waits for the period match
      applied[i] = release_req[i] & (~pwm_mode | cycle_start);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_req <= '0;
    end else begin
      release_req <= (release_req & ~applied)
        | ({NM{wr_release}} & pwdata[NM-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NM; i++) begin
        shadow[i] <= '0;
      end
    end else if (wr) begin
      for (int i = 0; i < NM; i++) begin
        if (paddr == mpt_pkg::OFS_MATCH_BASE + 12'(STRIDE * i)) begin
          shadow[i] <= pwdata[W-1:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NM; i++) begin
        active[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NM; i++) begin
        if (applied[i]) begin
          active[i] <= shadow[i];
        end
      end
    end
  end

  // ---- modulated outputs: output k uses match k for its fall
  // a fall on the period match wins, which gives the constant-low case
  for (genvar k = 1; k <= mpt_pkg::NPWM; k++) begin : g_pwm
    logic set_ev;
    logic dbl;
    assign dbl = pwm_ctrl[mpt_pkg::PCR_DBL_LO+k-1];
    assign set_ev = dbl ? hit[k-1] : hit[0];
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pwm_out[k-1] <= 1'b0;
      end else if (!pwm_mode || !pwm_ctrl[mpt_pkg::PCR_ENA_LO+k-1]) begin
        pwm_out[k-1] <= 1'b0;
      end else if (hit[k]) begin
        pwm_out[k-1] <= 1'b0;
      end else if (set_ev) begin
        pwm_out[k-1] <= 1'b1;
      end
    end
  end

  // ---- external match outputs; a match wins over a software write
  for (genvar e = 0; e < mpt_pkg::NEXT; e++) begin : g_ext
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        match_out[e] <= 1'b0;
      end else if (hit[e]) begin
        case (ext_act[2*e +: 2])
          mpt_pkg::EXT_LOW: match_out[e] <= 1'b0;
          mpt_pkg::EXT_HIGH: match_out[e] <= 1'b1;
          mpt_pkg::EXT_TOGGLE: match_out[e] <= ~match_out[e];
          default: match_out[e] <= match_out[e];
        endcase
      end else if (wr_ext) begin
        match_out[e] <= pwdata[e];
      end
    end
  end

  // ---- interrupts: sticky status, set wins over clear
  assign events = {cap_hit & cap_int_mask(cap_ctrl), hit & int_mask};

  function automatic logic [NC-1:0] cap_int_mask(input logic [NC*mpt_pkg::CCR_W-1:0] cc);
    logic [NC-1:0] r;
    r = '0;
    for (int i = 0; i < NC; i++) begin
      r[i] = cc[i*mpt_pkg::CCR_W+mpt_pkg::CCR_INT];
    end
    return r;
  endfunction : cap_int_mask

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (wr_clear) begin
      status <= (status & ~pwdata[mpt_pkg::ST_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      // registered, so irq trails its status bit by one cycle
      irq <= |(status & int_en);
    end
  end

  // ---- read decode
  always_comb begin
    addr_ok = 1'b1;
    next_rdata = mpt_pkg::RST_WORD;
    case (paddr)
      mpt_pkg::OFS_STATUS: next_rdata[mpt_pkg::ST_W-1:0] = status;
      mpt_pkg::OFS_CLEAR: next_rdata = mpt_pkg::RST_WORD;
      mpt_pkg::OFS_ENABLE: next_rdata[mpt_pkg::ST_W-1:0] = int_en;
      mpt_pkg::OFS_CTRL: next_rdata[mpt_pkg::CTRL_W-1:0] = ctrl;
      mpt_pkg::OFS_COUNT: next_rdata[W-1:0] = tc;
      mpt_pkg::OFS_PSC_TERM: next_rdata[W-1:0] = psc_term;
      mpt_pkg::OFS_PSC_COUNT: next_rdata[W-1:0] = presc.count;
      mpt_pkg::OFS_MATCH_CTRL: next_rdata[NM*mpt_pkg::MCR_W-1:0] = match_ctrl;
      mpt_pkg::OFS_RELEASE: next_rdata[NM-1:0] = release_req;
      mpt_pkg::OFS_PWM_CTRL: next_rdata[15:0] = pwm_ctrl;
      mpt_pkg::OFS_CAP_CTRL: next_rdata[NC*mpt_pkg::CCR_W-1:0] = cap_ctrl;
      mpt_pkg::OFS_EXT_CTRL: begin
        next_rdata[mpt_pkg::NEXT-1:0] = match_out;
        next_rdata[mpt_pkg::EXT_ACT_LO +: 2*mpt_pkg::NEXT] = ext_act;
      end
      default: begin
        addr_ok = 1'b0;
        for (int i = 0; i < NM; i++) begin
          if (paddr == mpt_pkg::OFS_MATCH_BASE + 12'(STRIDE * i)) begin
            addr_ok = 1'b1;
            next_rdata[W-1:0] = shadow[i];
          end
        end
        for (int i = 0; i < NC; i++) begin
          if (paddr == mpt_pkg::OFS_CAP_BASE + 12'(STRIDE * i)) begin
            addr_ok = 1'b1;
            next_rdata[W-1:0] = cap_val[i];
          end
        end
      end
    endcase
  end

  // read data is registered in the setup cycle and valid through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= mpt_pkg::RST_WORD;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end
endmodule : mpt_timer

// File: tb/mpt_timer_assertions.sv
// concurrent checks on the ports of the pwm timer top
module mpt_timer_chk (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [mpt_pkg::AW-1:0] paddr, // apb address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic sync_en_in, // master enable
  input wire logic sync_en_out, // enable out
  input wire logic [mpt_pkg::NPWM-1:0] pwm_out, // pwm outputs
  input wire logic [mpt_pkg::NEXT-1:0] match_out, // match outputs
  input wire logic irq // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (
    psel && penable |-> pready) else $error("pready low in access");
  chk_err_unmapped: assert property (
    psel && penable && paddr == 12'h030 |-> pslverr) else $error("unmapped not refused");
  chk_err_mapped: assert property (
    !(psel && penable) || (paddr < 12'h030 && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("error on mapped or idle bus");
  chk_rdata_unmapped: assert property (
    psel && !penable && !pwrite && paddr == 12'h030 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("read data moved");
  chk_sync_follow: assert property (
    psel && penable && pwrite && paddr == mpt_pkg::OFS_CTRL |=> sync_en_out == $past(pwdata[0]))
    else $error("enable out differs from written enable");
  chk_pwm_off: assert property (
    psel && penable && pwrite && paddr == mpt_pkg::OFS_CTRL && !pwdata[2] |-> ##2 pwm_out == '0)
    else $error("pwm output active outside pwm mode");
  chk_ext_load: assert property (
    psel && penable && pwrite && paddr == mpt_pkg::OFS_EXT_CTRL && !sync_en_out && !sync_en_in
    |=> match_out == $past(pwdata[3:0])) else $error("match outputs not loaded");
  chk_irq_off: assert property (
    psel && penable && pwrite && paddr == mpt_pkg::OFS_ENABLE && pwdata == 32'h0 |-> ##2 !irq)
    else $error("interrupt stays up with every source masked");
  chk_reset_quiet: assert property (
    $rose(presetn) |-> pwm_out == '0 && match_out == '0 && !irq && !sync_en_out)
    else $error("outputs not quiet after reset");
endmodule : mpt_timer_chk

bind mpt_timer mpt_timer_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sync_en_in(sync_en_in), .sync_en_out(sync_en_out),
  .pwm_out(pwm_out), .match_out(match_out), .irq(irq));

// File: tb/mpt_timer_tb.sv
// self-checking bench for the match-based pwm timer
module mpt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  localparam logic [5:0] DBL = 6'h04;
  localparam logic [5:0] ENA = 6'h0f;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [mpt_pkg::AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [mpt_pkg::NCAP-1:0] cap_in = '0;
  logic sync_en_in = 1'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sync_en_out, irq;
  logic [mpt_pkg::NPWM-1:0] pwm_out;
  logic [mpt_pkg::NEXT-1:0] match_out;
  int err_total = 0, tests_run = 0, cyc = 0, t1, t2;
  int cnt [6];
  logic [31:0] seed = 32'h0000_7abc;
  logic [32:0] exp_q[$];
  logic [31:0] m [7];

  mpt_timer #(.W(32)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .sync_en_in(sync_en_in), .sync_en_out(sync_en_out),
    .pwm_out(pwm_out), .match_out(match_out), .irq(irq));

  always #25 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [11:0] ofs(input int i);
    if (i < 12) return 12'(4 * i);
    if (i < 19) return mpt_pkg::OFS_MATCH_BASE + 12'(4 * (i - 12));
    return mpt_pkg::OFS_CAP_BASE + 12'(4 * (i - 19));
  endfunction : ofs

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [mpt_pkg::AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer

  task automatic wr(input logic [mpt_pkg::AW-1:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr

  // the expected {pslverr, prdata} is noted before the read goes out
  task automatic rd(input logic [mpt_pkg::AW-1:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'h0, a, 32'h0);
  endtask : rd

  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      @(posedge pclk);
      cap_in[ch] <= 1'h1;
      repeat (2) @(posedge pclk);
      cap_in[ch] <= 1'h0;
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
  endtask : pulse

  task automatic wait_irq(output int t);
    while (irq !== 1'h1) @(posedge pclk);
    t = cyc;
  endtask : wait_irq

  // high cycles per output over one period, from the active match values
  task automatic pwm_expect(input logic [31:0] a [7]);
    int p, s, hi;
    p = a[0] + 1;
    repeat (2 * p) @(posedge pclk);
    cnt = '{default: 0};
    repeat (p) begin
      @(posedge pclk);
      for (int k = 0; k < 6; k++) if (pwm_out[k] !== 1'h0) cnt[k]++;
    end
    for (int k = 1; k <= 6; k++) begin
      s = DBL[k-1] ? a[k-1] : a[0];
      hi = ENA[k-1] ? (a[k] - s + p) % p : 0;
      check(33'(cnt[k-1]), 33'(hi));
    end
  endtask : pwm_expect

  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 23; i++) rd(ofs(i), 33'h0);
    rd(12'h030, 33'h1_0000_0000);
    wr(mpt_pkg::OFS_COUNT, xs());
    rd(mpt_pkg::OFS_COUNT, 33'h0);
    for (int i = 0; i < 7; i++) begin
      m[i] = xs();
      wr(ofs(12 + i), m[i]);
    end
    for (int i = 0; i < 7; i++) rd(ofs(12 + i), {1'h0, m[i]});
    // reset-on-match period in timer mode, then masking and clearing
    wr(mpt_pkg::OFS_PSC_TERM, 32'h2);
    wr(mpt_pkg::OFS_MATCH_BASE, 32'h4);
    wr(mpt_pkg::OFS_RELEASE, 32'h1);
    wr(mpt_pkg::OFS_MATCH_CTRL, 32'h3);
    wr(mpt_pkg::OFS_ENABLE, 32'h1);
    wr(mpt_pkg::OFS_CTRL, 32'h1);
    wait_irq(t1);
    wr(mpt_pkg::OFS_CLEAR, 32'h1);
    repeat (3) @(posedge pclk);
    wait_irq(t2);
    check(33'(t2 - t1), 33'h0f);
    wr(mpt_pkg::OFS_ENABLE, 32'h0);
    repeat (20) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    wr(mpt_pkg::OFS_CTRL, 32'h0);
    rd(mpt_pkg::OFS_STATUS, 33'h1);
    wr(mpt_pkg::OFS_CLEAR, 32'h1);
    rd(mpt_pkg::OFS_STATUS, 33'h0);
    // pwm: shadows written but held back until released
    wr(mpt_pkg::OFS_MATCH_CTRL, 32'h0);
    wr(mpt_pkg::OFS_PSC_TERM, 32'h0);
    wr(mpt_pkg::OFS_PWM_CTRL, 32'h0000_0f04);
    wr(mpt_pkg::OFS_CTRL, 32'h2);
    wr(mpt_pkg::OFS_CTRL, 32'h5);
    m = '{32'h9, xs() % 32'ha, 32'h7, xs() % 32'ha, 32'h9, 32'h0, 32'h0};
    for (int i = 0; i < 5; i++) wr(ofs(12 + i), m[i]);
    pwm_expect('{0: 32'h4, default: 32'h0});
    wr(mpt_pkg::OFS_RELEASE, 32'h1f);
    pwm_expect(m);
    rd(mpt_pkg::OFS_RELEASE, 33'h0);
    // counter mode on capture input 2 for every edge choice
    wr(mpt_pkg::OFS_PSC_TERM, 32'h1);
    for (int e = 1; e <= 3; e++) begin
      wr(mpt_pkg::OFS_CTRL, 32'h2);
      wr(mpt_pkg::OFS_CTRL, 32'h89 | 32'(e << 4));
      pulse(2, 5);
      rd(mpt_pkg::OFS_COUNT, (e == 3) ? 33'h5 : 33'h2);
      rd(mpt_pkg::OFS_PSC_COUNT, (e == 3) ? 33'h0 : 33'h1);
    end
    wr(mpt_pkg::OFS_CAP_CTRL, 32'h5);
    wr(mpt_pkg::OFS_ENABLE, 32'h80);
    pulse(0, 1);
    rd(mpt_pkg::OFS_CAP_BASE, 33'h5);
    rd(mpt_pkg::OFS_STATUS, 33'h80);
    check({32'h0, irq}, 33'h1);
    wr(mpt_pkg::OFS_CLEAR, 32'h80);
    repeat (2) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    // match outputs: low, high, toggle and none on one hit
    wr(mpt_pkg::OFS_PSC_TERM, 32'h0);
    wr(mpt_pkg::OFS_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) wr(ofs(12 + i), 32'h1);
    wr(mpt_pkg::OFS_RELEASE, 32'hf);
    wr(mpt_pkg::OFS_EXT_CTRL, 32'h0000_0395);
    wr(mpt_pkg::OFS_CTRL, 32'h99);
    pulse(2, 2);
    check({29'h0, match_out}, 33'h2);
    // slave counts only while the master enable is high
    wr(mpt_pkg::OFS_CTRL, 32'h2);
    wr(mpt_pkg::OFS_CTRL, 32'h198);
    sync_en_in <= 1'h1;
    pulse(2, 3);
    sync_en_in <= 1'h0;
    pulse(2, 2);
    rd(mpt_pkg::OFS_COUNT, 33'h3);
    // stop on match clears the enable
    wr(mpt_pkg::OFS_CTRL, 32'h2);
    wr(mpt_pkg::OFS_MATCH_BASE, 32'h2);
    wr(mpt_pkg::OFS_RELEASE, 32'h1);
    wr(mpt_pkg::OFS_MATCH_CTRL, 32'h4);
    wr(mpt_pkg::OFS_CTRL, 32'h99);
    pulse(2, 5);
    check({32'h0, sync_en_out}, 33'h0);
    check(33'(exp_q.size()), 33'h0);
    final_report();
  end
endmodule : mpt_timer_tb
